// ### rtl/ecmp_map.svh
`ifndef ECMP_MAP_SVH
`define ECMP_MAP_SVH

// Register byte offsets
`define ECMP_OFS_CTL0 6'h00
`define ECMP_OFS_PER_HI 6'h02
`define ECMP_OFS_PER_LO 6'h03
`define ECMP_OFS_CHAN_BASE 6'h10
`define ECMP_OFS_DUTY_BASE 6'h20

// Control register 0 field positions
`define ECMP_CTL0_PRE_HI 6
`define ECMP_CTL0_PRE_LO 5
`define ECMP_CTL0_FAST 4
`define ECMP_CTL0_DITHER_ENABLE 3

// Channel control field positions
`define ECMP_CHAN_MODE_HI 7
`define ECMP_CHAN_MODE_LO 6
`define ECMP_CHAN_ALIGN_HI 5
`define ECMP_CHAN_ALIGN_LO 4

// Duty register layout
`define ECMP_DUTY_SIGN 15

// Reset values
`define ECMP_RST_CTL0 8'h00
`define ECMP_RST_PER 11'h000
`define ECMP_RST_CHAN 8'h00
`define ECMP_RST_DUTY 16'h0000

// Sizes
`define ECMP_NUM_CHAN 8
`define ECMP_NUM_PINS 16

`endif

// ### rtl/ecmp_pkg.sv
package ecmp_pkg;

	// Per-channel output drive mode
	typedef enum logic [1:0] {
		mode_half_minus = 2'b00,
		mode_half_plus = 2'b01,
		mode_full = 2'b10,
		mode_dual = 2'b11
	} ecmp_mode_e;

	// Per-channel waveform alignment
	typedef enum logic [1:0] {
		align_off = 2'b00,
		align_left = 2'b01,
		align_right = 2'b10,
		align_center = 2'b11
	} ecmp_align_e;

	typedef logic [10:0] ecmp_count_t;

endpackage

// ### rtl/ecmp_top.sv
// Overview of operation
// - Eight channels, two pins each, sixteen outputs.
// - Global bit picks 11-bit or 7-bit resolution.
// - Fast mode: one byte write updates duty.
// - 10/11-bit counter; dithering restores 11-bit resolution.
// - Global dither bit applies to all channels.
// - Mode 11 on a pair's even channel joins the pair, four pins.
// - Mode 10 drives both pins as H-bridge.
// - Modes 00/01 drive only one pin.
// - Output mode chosen per channel, pairing restricted.
// - Pair n is channels 2n and 2n+1.
// - Left, right or centre alignment per channel.
// - PWM on minus, plus high: positive current.
`timescale 1ns/1ps
`include "ecmp_map.svh"

module ecmp_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rst_b,
	// Register port
	input wire logic [5:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// Motor 0 pins
	output logic o_motor0_coil0_minus,
	output logic o_motor0_coil0_plus,
	output logic o_motor0_coil1_minus,
	output logic o_motor0_coil1_plus,
	// Motor 1 pins
	output logic o_motor1_coil0_minus,
	output logic o_motor1_coil0_plus,
	output logic o_motor1_coil1_minus,
	output logic o_motor1_coil1_plus,
	// Motor 2 pins
	output logic o_motor2_coil0_minus,
	output logic o_motor2_coil0_plus,
	output logic o_motor2_coil1_minus,
	output logic o_motor2_coil1_plus,
	// Motor 3 pins
	output logic o_motor3_coil0_minus,
	output logic o_motor3_coil0_plus,
	output logic o_motor3_coil1_minus,
	output logic o_motor3_coil1_plus
);

	// Software-visible state
	logic [7:0] ctl0_r;
	logic [10:0] period_r;
	logic [7:0] chan_ctl_r [0:`ECMP_NUM_CHAN-1];
	logic [15:0] duty_r [0:`ECMP_NUM_CHAN-1];
	logic [7:0] duty_hi_buf_r;
	logic [7:0] rdata_r;

	// Timebase state
	logic [2:0] div_cnt_r;
	logic [1:0] pre_act_r;
	logic [10:0] period_act_r;
	logic [10:0] cnt_r;
	logic odd_period_r;

	// Output pin image, index 2c is minus and 2c+1 plus of channel c
	logic [`ECMP_NUM_PINS-1:0] pins_r;
	logic [`ECMP_NUM_PINS-1:0] pins_nxt;

	// Global controls
	logic fast_mode;
	logic dither_enable;
	logic [1:0] prescale_sel;

	assign fast_mode = ctl0_r[`ECMP_CTL0_FAST];
	assign dither_enable = ctl0_r[`ECMP_CTL0_DITHER_ENABLE];
	assign prescale_sel = ctl0_r[`ECMP_CTL0_PRE_HI:`ECMP_CTL0_PRE_LO];

	// Address decode
	logic hit_chan;
	logic hit_duty;
	logic [2:0] chan_idx;
	logic [2:0] duty_idx;

	assign hit_chan = (i_addr[5:3] == 3'(`ECMP_OFS_CHAN_BASE >> 3));
	assign hit_duty = (i_addr[5:4] == 2'(`ECMP_OFS_DUTY_BASE >> 4));
	assign chan_idx = i_addr[2:0];
	assign duty_idx = i_addr[3:1];

	// Global control register write
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ctl0_r <= `ECMP_RST_CTL0;
		end else if (i_wr && i_addr == `ECMP_OFS_CTL0) begin
			ctl0_r <= {1'b0, i_wdata[6:3], 3'h0};
		end
	end

	// Period register write, taken into the counter at period end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			period_r <= `ECMP_RST_PER;
		end else if (i_wr && i_addr == `ECMP_OFS_PER_HI) begin
			period_r[10:8] <= i_wdata[2:0];
		end else if (i_wr && i_addr == `ECMP_OFS_PER_LO) begin
			period_r[7:0] <= i_wdata;
		end
	end

	// Channel control registers, one per channel
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int c = 0; c < `ECMP_NUM_CHAN; c++) begin
				chan_ctl_r[c] <= `ECMP_RST_CHAN;
			end
		end else if (i_wr && hit_chan) begin
			chan_ctl_r[chan_idx] <= {i_wdata[7:4], 4'h0};
		end
	end

	// High byte buffer so an 11-bit duty never shows half-written
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			duty_hi_buf_r <= 8'h00;
		end else if (i_wr && hit_duty && !i_addr[0]) begin
			duty_hi_buf_r <= i_wdata;
		end
	end

	// Duty registers: fast mode commits on the high byte alone
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int c = 0; c < `ECMP_NUM_CHAN; c++) begin
				duty_r[c] <= `ECMP_RST_DUTY;
			end
		end else if (i_wr && hit_duty) begin
			if (fast_mode && !i_addr[0]) begin
				duty_r[duty_idx] <= {i_wdata, 8'h00};
			end else if (!fast_mode && i_addr[0]) begin
				duty_r[duty_idx] <= {duty_hi_buf_r, i_wdata};
			end
		end
	end

	// Read mux, data valid only in the cycle after the strobe
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_r <= 8'h00;
		end else if (!i_rd) begin
			rdata_r <= 8'h00;
		end else if (i_addr == `ECMP_OFS_CTL0) begin
			rdata_r <= ctl0_r;
		end else if (i_addr == `ECMP_OFS_PER_HI) begin
			rdata_r <= {5'h00, period_r[10:8]};
		end else if (i_addr == `ECMP_OFS_PER_LO) begin
			rdata_r <= period_r[7:0];
		end else if (hit_chan) begin
			rdata_r <= chan_ctl_r[chan_idx];
		end else if (hit_duty && !i_addr[0]) begin
			rdata_r <= duty_r[duty_idx][15:8];
		end else if (hit_duty) begin
			rdata_r <= duty_r[duty_idx][7:0];
		end else begin
			rdata_r <= 8'h00; // Reserved reads zero
		end
	end

	assign o_rdata = rdata_r;

	// Prescaler: counter advances on a one-cycle enable
	logic tick;
	logic [2:0] pre_mask;

	assign pre_mask = 3'(({1'b0, 3'h1} << pre_act_r) - 4'h1);
	assign tick = (div_cnt_r & pre_mask) == pre_mask;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			div_cnt_r <= 3'h0;
		end else begin
			div_cnt_r <= tick ? 3'h0 : div_cnt_r + 3'h1;
		end
	end

	// Counter limit: dithering halves the counter to 10 bits
	logic [10:0] cnt_lim;
	logic period_end;

	assign cnt_lim = dither_enable ? {1'b0, period_act_r[10:1]} : period_act_r;
	assign period_end = tick && (cnt_r + 11'h1 >= cnt_lim);

	// PWM counter; period and prescaler only change at period end
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_r <= 11'h000;
			period_act_r <= `ECMP_RST_PER;
			pre_act_r <= 2'h0;
			odd_period_r <= 1'b0;
		end else if (period_end) begin
			cnt_r <= 11'h000;
			period_act_r <= period_r;
			pre_act_r <= prescale_sel;
			odd_period_r <= ~odd_period_r;
		end else if (tick) begin
			cnt_r <= cnt_r + 11'h001;
		end
	end

	// Per-channel waveform and pin drive
	for (genvar c = 0; c < `ECMP_NUM_CHAN; c++) begin : g_chan
		ecmp_pkg::ecmp_count_t mag;
		ecmp_pkg::ecmp_count_t eff;
		ecmp_pkg::ecmp_mode_e mode;
		ecmp_pkg::ecmp_align_e align;
		logic [11:0] start;
		logic sign;
		logic pwm;
		logic [1:0] pin_pair;

		// 7-bit magnitude scales to the 11-bit range
		assign mag = fast_mode ? {duty_r[c][14:8], 4'h0} : duty_r[c][10:0];
		assign sign = duty_r[c][`ECMP_DUTY_SIGN];

		// Odd periods add the lost LSB back, averaging to 11 bits
		assign eff = dither_enable ? 11'({1'b0, mag[10:1]} + {10'h000, mag[0] & odd_period_r})
			: mag;

		// Pair's even channel in mode 11 forces both into dual drive
		assign mode = ecmp_pkg::ecmp_mode_e'(
			(chan_ctl_r[c & ~1][`ECMP_CHAN_MODE_HI:`ECMP_CHAN_MODE_LO] == 2'b11) ? 2'b11
			: (chan_ctl_r[c][`ECMP_CHAN_MODE_HI:`ECMP_CHAN_MODE_LO] == 2'b11) ? 2'b10
			: chan_ctl_r[c][`ECMP_CHAN_MODE_HI:`ECMP_CHAN_MODE_LO]);
		assign align = ecmp_pkg::ecmp_align_e'(
			chan_ctl_r[c][`ECMP_CHAN_ALIGN_HI:`ECMP_CHAN_ALIGN_LO]);

		// Centre pulse starts half the idle time into the period
		assign start = ({1'b0, cnt_lim} > {1'b0, eff}) ? ({1'b0, cnt_lim} - {1'b0, eff}) >> 1
			: 12'h000;

		// Alignment decides where in the period the pulse sits
		always_comb begin
			case (align)
				ecmp_pkg::align_left: begin
					pwm = cnt_r < eff;
				end
				ecmp_pkg::align_right: begin
					pwm = ({1'b0, cnt_r} + {1'b0, eff}) >= {1'b0, cnt_lim};
				end
				ecmp_pkg::align_center: begin
					pwm = ({1'b0, cnt_r} >= start) && ({1'b0, cnt_r} < start + {1'b0, eff});
				end
				default: begin
					pwm = 1'b0;
				end
			endcase
		end

		// Pin drive: bit 0 minus, bit 1 plus; bridge conducts while the pulsed end is low
		always_comb begin
			case (mode)
				ecmp_pkg::mode_half_minus: begin
					pin_pair = {1'b0, pwm};
				end
				ecmp_pkg::mode_half_plus: begin
					pin_pair = {pwm, 1'b0};
				end
				ecmp_pkg::mode_full, ecmp_pkg::mode_dual: begin
					pin_pair = sign ? {~pwm, 1'b1} : {1'b1, ~pwm};
				end
				default: begin
					pin_pair = 2'b00;
				end
			endcase
			if (align == ecmp_pkg::align_off) begin
				pin_pair = 2'b00;
			end
		end

		assign pins_nxt[2*c+1:2*c] = pin_pair;
	end

	// Registered pins so no decode glitch reaches a coil
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pins_r <= 16'h0000;
		end else begin
			pins_r <= pins_nxt;
		end
	end

	// Pin map: channel 2n is coil 0 and 2n+1 coil 1 of motor n
	assign o_motor0_coil0_minus = pins_r[0];
	assign o_motor0_coil0_plus = pins_r[1];
	assign o_motor0_coil1_minus = pins_r[2];
	assign o_motor0_coil1_plus = pins_r[3];
	assign o_motor1_coil0_minus = pins_r[4];
	assign o_motor1_coil0_plus = pins_r[5];
	assign o_motor1_coil1_minus = pins_r[6];
	assign o_motor1_coil1_plus = pins_r[7];
	assign o_motor2_coil0_minus = pins_r[8];
	assign o_motor2_coil0_plus = pins_r[9];
	assign o_motor2_coil1_minus = pins_r[10];
	assign o_motor2_coil1_plus = pins_r[11];
	assign o_motor3_coil0_minus = pins_r[12];
	assign o_motor3_coil0_plus = pins_r[13];
	assign o_motor3_coil1_minus = pins_r[14];
	assign o_motor3_coil1_plus = pins_r[15];

endmodule

// ### testbench/ecmp_coils.sv
`timescale 1ns/1ps
module ecmp_coils (
	// Clock and count clear
	input wire logic i_clk,
	input wire logic i_clr,
	// Minus pin even, plus pin odd
	input wire logic [15:0] i_pin,
	// On-cycles per coil and direction
	output logic [7:0] o_pos [8],
	output logic [7:0] o_neg [8]
);
	// Current flows only while the coil ends differ
	always_ff @(posedge i_clk) begin
		for (int k = 0; k < 8; k++) begin
			o_pos[k] <= i_clr ? 8'h00 : o_pos[k] + {7'h00, i_pin[2*k+1] & ~i_pin[2*k]};
			o_neg[k] <= i_clr ? 8'h00 : o_neg[k] + {7'h00, i_pin[2*k] & ~i_pin[2*k+1]};
		end
	end
endmodule

// ### testbench/ecmp_top_sva.sv
`timescale 1ns/1ps
module ecmp_top_sva (
	// Clock, reset, register port
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [5:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	// Coil pins
	input wire logic o_motor0_coil0_minus, o_motor0_coil0_plus,
	o_motor0_coil1_minus, o_motor0_coil1_plus, o_motor1_coil0_minus, o_motor1_coil0_plus,
	o_motor1_coil1_minus, o_motor1_coil1_plus, o_motor2_coil0_minus, o_motor2_coil0_plus,
	o_motor2_coil1_minus, o_motor2_coil1_plus, o_motor3_coil0_minus, o_motor3_coil0_plus,
	o_motor3_coil1_minus, o_motor3_coil1_plus
);
	logic [15:0] pv;
	logic [7:0] cc_r [8];
	logic [7:0] rx_r;
	// Pins by channel, minus below plus
	assign pv = {o_motor3_coil1_plus, o_motor3_coil1_minus, o_motor3_coil0_plus,
		o_motor3_coil0_minus, o_motor2_coil1_plus, o_motor2_coil1_minus, o_motor2_coil0_plus,
		o_motor2_coil0_minus, o_motor1_coil1_plus, o_motor1_coil1_minus, o_motor1_coil0_plus,
		o_motor1_coil0_minus, o_motor0_coil1_plus, o_motor0_coil1_minus, o_motor0_coil0_plus,
		o_motor0_coil0_minus};
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	// Shadow of channel control; rx_r holds pre-write value
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			for (int k = 0; k < 8; k++) cc_r[k] <= 8'h00;
			rx_r <= 8'h00;
		end else begin
			if (i_wr && i_addr[5:3] == 3'b010) cc_r[i_addr[2:0]] <= i_wdata & 8'hf0;
			rx_r <= cc_r[i_addr[2:0]];
		end
	end
	AST_RD_IDLE:
		assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("stray read data");
	AST_RD_RSVD:
		assert property ($past(i_rd) && $past(i_addr[5:4]) == 2'b11 |-> o_rdata == 8'h00)
			else $error("reserved read not zero");
	AST_RD_CHAN:
		assert property ($past(i_rd) && $past(i_addr[5:3]) == 3'b010 |-> o_rdata == rx_r)
			else $error("channel control readback wrong");
	AST_PINS_RESET:
		assert property (!$past(i_rst_b) |-> pv == 16'h0000) else $error("pins busy after reset");
	// Config must be settled a cycle before pins follow it
	for (genvar c = 0; c < 8; c++) begin : g_ch
		logic [1:0] md, al;
		logic br;
		assign md = cc_r[c][7:6];
		assign al = cc_r[c][5:4];
		assign br = md[1] || cc_r[c & 6][7:6] == 2'b11;
		AST_ALIGN_OFF:
			assert property (!$past(i_wr) && al == 2'b00 |-> pv[2*c+1:2*c] == 2'b00)
				else $error("disabled channel drives");
		AST_HALF_MINUS:
			assert property (!$past(i_wr) && !br && md == 2'b00 |-> !pv[2*c+1])
				else $error("half mode uses plus pin");
		AST_HALF_PLUS:
			assert property (!$past(i_wr) && !br && md == 2'b01 |-> !pv[2*c])
				else $error("half mode uses minus pin");
		AST_BRIDGE:
			assert property (!$past(i_wr) && br && al != 2'b00 |-> pv[2*c] || pv[2*c+1])
				else $error("bridge lost its held end");
	end
endmodule

bind ecmp_top ecmp_top_sva u_ecmp_top_sva (.*);

// ### testbench/ecmp_top_tb.sv
`timescale 1ns/1ps
module ecmp_top_tb;
	logic i_clk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, clr = 1, pend = 0, w, f, s;
	logic [5:0] i_addr = 0, a;
	logic [7:0] i_wdata = 0, o_rdata, rexp = 0, pexp = 0, e, mir [64], pos [8], neg [8];
	logic [15:0] pin;
	logic [6:0] m;
	logic [2:0] c;
	logic [1:0] md, al;
	int n_mismatch = 0, check_count = 0, seed = 10820;
	ecmp_top u_ecmp_top (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.o_motor0_coil0_minus(pin[0]), .o_motor0_coil0_plus(pin[1]),
		.o_motor0_coil1_minus(pin[2]), .o_motor0_coil1_plus(pin[3]),
		.o_motor1_coil0_minus(pin[4]), .o_motor1_coil0_plus(pin[5]),
		.o_motor1_coil1_minus(pin[6]), .o_motor1_coil1_plus(pin[7]),
		.o_motor2_coil0_minus(pin[8]), .o_motor2_coil0_plus(pin[9]),
		.o_motor2_coil1_minus(pin[10]), .o_motor2_coil1_plus(pin[11]),
		.o_motor3_coil0_minus(pin[12]), .o_motor3_coil0_plus(pin[13]),
		.o_motor3_coil1_minus(pin[14]), .o_motor3_coil1_plus(pin[15]));
	ecmp_coils u_ecmp_coils (.i_clk, .i_clr(clr), .i_pin(pin), .o_pos(pos), .o_neg(neg));
	// 100 ns clock
	initial forever #50 i_clk = ~i_clk;
	task final_report;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// Watchdog well beyond the planned run
	initial begin
		repeat (20000) @(posedge i_clk);
		n_mismatch++;
		final_report;
	end
	task automatic check(input string what, input logic [7:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask
	// Implemented bits; holes read zero
	function automatic logic [7:0] msk(input logic [5:0] ad);
		if (ad == 6'h00) return 8'h78;
		if (ad == 6'h02) return 8'h07;
		if (ad == 6'h03) return 8'hff;
		return (ad[5:3] == 3'b010) ? 8'hf0 : 8'h00;
	endfunction
	// Strobes stay up across calls so transfers run back to back
	task automatic bus(input logic wr, rd, input logic [5:0] ad, input logic [7:0] d);
		i_wr <= wr;
		i_rd <= rd;
		i_addr <= ad;
		i_wdata <= d;
		rexp <= mir[ad];
		if (wr) mir[ad] = d & msk(ad);
		@(posedge i_clk);
	endtask
	task rst;
		i_rst_b <= 0;
		repeat (3) @(posedge i_clk);
		i_rst_b <= 1;
		foreach (mir[k]) mir[k] = 8'h00;
	endtask
	// Read data is judged in the cycle after its strobe
	always @(posedge i_clk) begin
		if (pend) check("rdata", o_rdata, pexp);
		pend <= i_rd;
		pexp <= rexp;
	end
	initial begin
		rst;
		for (int k = 0; k < 64; k++) bus(0, 1, 6'(k), 8'h00);
		// Random traffic, duty bank steered to reserved space
		repeat (300) begin
			a = 6'($random(seed));
			if (a[5:4] == 2'b10) a[4] = 1'b1;
			w = $random(seed);
			bus(w, !w, a, 8'($random(seed)));
		end
		bus(0, 0, 6'h00, 8'h00);
		// Every mode, left/right/centre alignment, both resolutions, random dither
		for (int i = 0; i < 24; i++) begin
			rst;
			c = 3'($random(seed));
			md = 2'(i);
			al = 2'(1 + (i / 4) % 3);
			f = i >= 12;
			s = $random(seed);
			m = 7'($random(seed)) & (f ? 7'h03 : 7'h3f);
			e = f ? {1'b0, m[1:0], 5'h00} : {m, 1'b0};
			bus(1, 0, 6'h03, 8'h40);
			bus(1, 0, 6'h00, {3'h0, f, 1'($random(seed)), 3'h0});
			bus(1, 0, {2'b10, c, 1'b0}, {s, f ? m : 7'h00});
			bus(1, 0, {2'b10, c, 1'b1}, f ? 8'hff : {1'b0, m});
			bus(1, 0, {3'b010, c}, {md, al, 4'h0});
			bus(!c[0] && md == 2'b11, 0, {3'b010, c | 3'h1}, 8'h10);
			bus(0, 0, 6'h00, 8'h00);
			repeat (200) @(posedge i_clk);
			clr <= 0;
			repeat (128) @(posedge i_clk);
			#1;
			for (int k = 0; k < 8; k++) begin
				check("pos", pos[k], (k == c && (md == 2'b01 || md[1] && !s)) ? e : 8'h00);
				check("neg", neg[k], (k == c && (md == 2'b00 || md[1] && s)) ? e : 8'h00);
			end
			clr <= 1;
		end
		final_report;
	end
endmodule
